// *** wiper_ctrl_pkg.sv ***
package wiper_ctrl_pkg;

    // geometry of the part
    localparam int NUM_CH = 4;
    localparam int NUM_SLOT = 4;
    localparam int NUM_SAVED = NUM_CH * NUM_SLOT;
    localparam int WIPER_W = 8;
    localparam int NUM_TAPS = 256;

    // fixed upper bits of the 7-bit bus address, the low four come from the straps
    localparam logic [2:0] ADDR_PREFIX = 3'h2;

    // instruction opcodes, upper nibble of the instruction byte
    localparam logic [3:0] OP_STEP = 4'h2;
    localparam logic [3:0] OP_READ_WIPER = 4'h9;
    localparam logic [3:0] OP_WRITE_WIPER = 4'hA;
    localparam logic [3:0] OP_READ_SAVED = 4'hB;
    localparam logic [3:0] OP_WRITE_SAVED = 4'hC;
    localparam logic [3:0] OP_RECALL = 4'hD;
    localparam logic [3:0] OP_STORE = 4'hE;

    // bit counting and reset values
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [7:0] WIPER_RST = 8'h00;
    localparam logic [7:0] WIPER_MAX = 8'hFF;
    localparam logic [7:0] WIPER_MIN = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] STRAP_RST = 4'h0;
    localparam logic GUARD_RST = 1'b0;
    localparam logic [NUM_TAPS-1:0] TAP_RST = 256'h1;

    // instruction byte layout
    typedef struct packed {
        logic [3:0] op;
        logic [1:0] slot;
        logic [1:0] chan;
    } instr_t;

    localparam instr_t INSTR_RST = '{op: 4'h0, slot: 2'h0, chan: 2'h0};

    // the two bus wires as sampled together
    typedef struct packed {
        logic scl;
        logic sda;
    } line_t;

    localparam line_t LINE_IDLE = '{scl: 1'b1, sda: 1'b1};

    // bus engine states, gray along the write path
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h3,
        ST_INSTR     = 4'h2,
        ST_INSTR_ACK = 4'h6,
        ST_DATA      = 4'h7,
        ST_DATA_ACK  = 4'h5,
        ST_SEND      = 4'h4,
        ST_SEND_ACK  = 4'hC
    } bus_state_t;

endpackage : wiper_ctrl_pkg

// *** wiper_tap_decode.sv ***
`timescale 1ns/1ns
`default_nettype none

module wiper_tap_decode (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    // wiper position in
    input wire logic [wiper_ctrl_pkg::WIPER_W-1:0] position,
    // one-hot tap switch drive
    output logic [wiper_ctrl_pkg::NUM_TAPS-1:0] tap_sel
);
    import wiper_ctrl_pkg::*;

    // one shifted bit can never light two switches
    wire [NUM_TAPS-1:0] onehot_w = TAP_RST << position;

    // registered so no decode glitch reaches the switches
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tap_sel <= TAP_RST;
        end else if (ce) begin
            tap_sel <= onehot_w;
        end
    end

endmodule : wiper_tap_decode

`default_nettype wire

// *** quad_wiper_register_control.sv ***
`timescale 1ns/1ns
`default_nettype none

// How it works
// - one private 8-bit wiper register per channel
// - four saved 8-bit settings per channel, sixteen
// - after reset recall first saved setting everywhere
// - guard low blocks saved writes, wiper still writable
// - respond only when address matches strap inputs
// - exactly one tap per channel, from wiper
// - 256 taps, full 8-bit wiper range
// - bus reads and writes wiper and saved registers
// - copy wiper to saved slot and back
// - step instruction moves wiper up or down
// - data line only pulled low, never driven high
module quad_wiper_register_control (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    // two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // address straps and write guard
    input wire logic bus_select_bit0,
    input wire logic bus_select_bit1,
    input wire logic bus_select_bit2,
    input wire logic bus_select_bit3,
    input wire logic write_guard_n,
    // channel outputs
    output wire logic [wiper_ctrl_pkg::NUM_CH-1:0][wiper_ctrl_pkg::WIPER_W-1:0] wiper_pos,
    output wire logic [wiper_ctrl_pkg::NUM_CH-1:0][wiper_ctrl_pkg::NUM_TAPS-1:0] tap_sel,
    // status
    output logic bus_active,
    output logic nv_refused
);
    import wiper_ctrl_pkg::*;

    // saved index: channel in the high pair, slot in the low pair
    function automatic logic [3:0] nv_index(input instr_t ins);
        return {ins.chan, ins.slot};
    endfunction : nv_index

    // opcodes that would touch the saved array
    function automatic logic is_nv_write(input logic [3:0] op);
        return (op == OP_WRITE_SAVED) || (op == OP_STORE);
    endfunction : is_nv_write

    // saturating step, an up step at the top end holds the top tap
    function automatic logic [7:0] step_wiper(input logic [7:0] cur, input logic up);
        logic [7:0] res;
        res = cur;
        if (up && (cur != WIPER_MAX)) begin
            res = cur + 8'h01;
        end else if (!up && (cur != WIPER_MIN)) begin
            res = cur - 8'h01;
        end
        return res;
    endfunction : step_wiper

    // synchronisers and edge history
    line_t line_m_q;
    line_t line_s_q;
    line_t line_p_q;
    logic [3:0] sel_m_q;
    logic [3:0] sel_s_q;
    logic guard_m_q;
    logic guard_s_q;

    // bus engine state
    bus_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    instr_t instr_q;
    logic rw_q;
    logic oe_q;
    logic mack_q;
    logic boot_done_q;
    logic refused_q;

    // register storage; the saved array has no reset on purpose,
    // it stands in for cells that keep their value across resets
    logic [7:0] wiper_q [NUM_CH];
    logic [7:0] nv_mem [NUM_SAVED];

    // write strobes shared by all bus sources; the boot recall loads the wipers directly
    logic wip_we;
    logic [1:0] wip_idx;
    logic [7:0] wip_val;
    logic nv_we;
    logic [3:0] nv_idx;
    logic [7:0] nv_val;

    // every bus pin passes two flops before any logic looks at it
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_m_q <= LINE_IDLE;
            line_s_q <= LINE_IDLE;
            line_p_q <= LINE_IDLE;
        end else if (ce) begin
            line_m_q <= '{scl: scl_i, sda: sda_i};
            line_s_q <= line_m_q;
            line_p_q <= line_s_q;
        end
    end

    // straps and guard; guard resets to blocked until sampled
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_m_q <= STRAP_RST;
            sel_s_q <= STRAP_RST;
            guard_m_q <= GUARD_RST;
            guard_s_q <= GUARD_RST;
        end else if (ce) begin
            sel_m_q <= {bus_select_bit3, bus_select_bit2, bus_select_bit1, bus_select_bit0};
            sel_s_q <= sel_m_q;
            guard_m_q <= write_guard_n;
            guard_s_q <= guard_m_q;
        end
    end

    // bus conditions seen on the synchronised wires
    wire start_w = line_s_q.scl & line_p_q.sda & ~line_s_q.sda;
    wire stop_w = line_s_q.scl & ~line_p_q.sda & line_s_q.sda;
    wire rise_w = line_s_q.scl & ~line_p_q.scl;
    wire fall_w = ~line_s_q.scl & line_p_q.scl;
    wire byte_full_w = (cnt_q == BYTE_BITS);
    wire addr_match_w = (shift_q[7:1] == {ADDR_PREFIX, sel_s_q});
    wire receiving_w = (state_q == ST_ADDR) || (state_q == ST_INSTR) || (state_q == ST_DATA);

    // execution moments: instruction at end of its ack, data at its eighth fall
    wire instr_exec_w = boot_done_q & (state_q == ST_INSTR_ACK) & fall_w;
    wire data_exec_w = boot_done_q & (state_q == ST_DATA) & fall_w & byte_full_w;
    wire guard_open_w = guard_s_q;

    // read selection follows the last instruction taken
    wire [7:0] nv_rd_w = nv_mem[nv_index(instr_q)];
    wire [7:0] wip_rd_w = wiper_q[instr_q.chan];
    wire [7:0] rd_val_w = (instr_q.op == OP_READ_SAVED) ? nv_rd_w : wip_rd_w;
    wire nv_block_w = (instr_exec_w | data_exec_w) & is_nv_write(instr_q.op) & ~guard_open_w;

    // one write source per cycle; recall/store act on the ack, writes on data
    always_comb begin
        wip_we = 1'b0;
        wip_idx = instr_q.chan;
        wip_val = WIPER_RST;
        nv_we = 1'b0;
        nv_idx = nv_index(instr_q);
        nv_val = BYTE_RST;
        if (instr_exec_w && (instr_q.op == OP_RECALL)) begin
            wip_we = 1'b1;
            wip_val = nv_rd_w;
        end else if (instr_exec_w && (instr_q.op == OP_STORE)) begin
            nv_we = guard_open_w;
            nv_val = wip_rd_w;
        end else if (data_exec_w) begin
            case (instr_q.op)
                OP_WRITE_WIPER: begin
                    wip_we = 1'b1;
                    wip_val = shift_q;
                end
                OP_WRITE_SAVED: begin
                    nv_we = guard_open_w;
                    nv_val = shift_q;
                end
                OP_STEP: begin
                    wip_we = 1'b1;
                    wip_val = step_wiper(wip_rd_w, shift_q[0]);
                end
                default: begin
                    wip_we = 1'b0;
                end
            endcase
        end
    end

    // saved array write port, no reset so contents survive rst_b
    always_ff @(posedge sys_clk) begin
        if (ce && nv_we) begin
            nv_mem[nv_idx] <= nv_val;
        end
    end

    // the recall runs once, on the first enabled cycle after release
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_done_q <= 1'b0;
        end else if (ce) begin
            boot_done_q <= 1'b1;
        end
    end

    // one wiper register and one tap decoder per channel
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : gen_ch
            localparam logic [1:0] CH_IDX = 2'(g);
            localparam logic [3:0] FIRST_SLOT = 4'(g * NUM_SLOT);

            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    wiper_q[g] <= WIPER_RST;
                end else if (ce) begin
                    if (!boot_done_q) begin
                        wiper_q[g] <= nv_mem[FIRST_SLOT];
                    end else if (wip_we && (wip_idx == CH_IDX)) begin
                        wiper_q[g] <= wip_val;
                    end
                end
            end

            assign wiper_pos[g] = wiper_q[g];

            wiper_tap_decode u_tap (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .ce(ce),
                .position(wiper_q[g]),
                .tap_sel(tap_sel[g])
            );
        end
    endgenerate

    // bus engine: shift in on rise, change the line only after a fall
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            cnt_q <= CNT_RST;
            shift_q <= BYTE_RST;
            tx_q <= BYTE_RST;
            instr_q <= INSTR_RST;
            rw_q <= 1'b0;
            oe_q <= 1'b0;
            mack_q <= 1'b0;
        end else if (ce) begin
            if (start_w) begin
                state_q <= ST_ADDR;
                cnt_q <= CNT_RST;
                oe_q <= 1'b0;
            end else if (stop_w) begin
                state_q <= ST_IDLE;
                oe_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_ADDR, ST_INSTR, ST_DATA: begin
                        if (rise_w && !byte_full_w) begin
                            shift_q <= {shift_q[6:0], line_s_q.sda};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (fall_w && byte_full_w) begin
                            cnt_q <= CNT_RST;
                            if (state_q == ST_ADDR) begin
                                // a foreign address leaves the line alone
                                if (addr_match_w) begin
                                    state_q <= ST_ADDR_ACK;
                                    oe_q <= 1'b1;
                                    rw_q <= shift_q[0];
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end else if (state_q == ST_INSTR) begin
                                state_q <= ST_INSTR_ACK;
                                oe_q <= 1'b1;
                                instr_q <= instr_t'(shift_q);
                            end else begin
                                state_q <= ST_DATA_ACK;
                                oe_q <= 1'b1;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (fall_w && rw_q) begin
                            state_q <= ST_SEND;
                            tx_q <= rd_val_w;
                            oe_q <= ~rd_val_w[7];
                        end else if (fall_w) begin
                            state_q <= ST_INSTR;
                            oe_q <= 1'b0;
                        end
                    end
                    ST_INSTR_ACK, ST_DATA_ACK: begin
                        if (fall_w) begin
                            state_q <= ST_DATA;
                            oe_q <= 1'b0;
                        end
                    end
                    ST_SEND: begin
                        if (rise_w && !byte_full_w) begin
                            cnt_q <= cnt_q + 4'h1;
                        end else if (fall_w && byte_full_w) begin
                            state_q <= ST_SEND_ACK;
                            cnt_q <= CNT_RST;
                            oe_q <= 1'b0;
                        end else if (fall_w) begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            oe_q <= ~tx_q[6];
                        end
                    end
                    ST_SEND_ACK: begin
                        // controller ack repeats the same register, nack ends
                        if (rise_w) begin
                            mack_q <= ~line_s_q.sda;
                        end else if (fall_w && mack_q) begin
                            state_q <= ST_SEND;
                            tx_q <= rd_val_w;
                            oe_q <= ~rd_val_w[7];
                        end else if (fall_w) begin
                            state_q <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                        oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // refusal flag: set wins over the clear at the next start
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            refused_q <= 1'b0;
        end else if (ce) begin
            if (nv_block_w) begin
                refused_q <= 1'b1;
            end else if (start_w) begin
                refused_q <= 1'b0;
            end
        end
    end

    // open drain: the driven level is always low
    assign sda_o = 1'b0;
    assign sda_oe = oe_q;
    assign bus_active = receiving_w | (state_q == ST_ADDR_ACK) | (state_q == ST_INSTR_ACK)
        | (state_q == ST_DATA_ACK) | (state_q == ST_SEND) | (state_q == ST_SEND_ACK);
    assign nv_refused = refused_q;

endmodule : quad_wiper_register_control

`default_nettype wire

// *** quad_wiper_register_control_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none

module quad_wiper_checker (
    // clock and controls
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic write_guard_n,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // channel and status outputs
    input wire logic [wiper_ctrl_pkg::NUM_CH-1:0][wiper_ctrl_pkg::WIPER_W-1:0] wiper_pos,
    input wire logic [wiper_ctrl_pkg::NUM_CH-1:0][wiper_ctrl_pkg::NUM_TAPS-1:0] tap_sel,
    input wire logic bus_active,
    input wire logic nv_refused
);
    import wiper_ctrl_pkg::*;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // saved slots start unknown, so wiper checks wait for the second reset release
    logic [1:0] rel_cnt_q = 2'h0;
    always_ff @(posedge rst_b) begin
        if (rel_cnt_q != 2'h2) rel_cnt_q <= rel_cnt_q + 2'h1;
    end
    wire logic armed = (rel_cnt_q == 2'h2);

    chk_pull_only: assert property (sda_o == 1'b0)
        else $error("data line driven high");
    chk_idle_released: assert property (!bus_active [*2] |-> !sda_oe)
        else $error("data line pulled while idle");
    chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data line moved while clock high");
    chk_start_scl_high: assert property ($rose(bus_active) |-> scl_i)
        else $error("transfer began without a start");
    chk_refused_guarded: assert property ($rose(nv_refused) |-> !write_guard_n)
        else $error("refusal flagged with guard open");
    // the recall lands on the first edge after release, so two edges are skipped
    chk_wiper_quiet: assert property (
        armed && !bus_active && $past(rst_b, 2) |-> $stable(wiper_pos))
        else $error("wiper moved with bus idle");

    // every channel decodes its own wiper only
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        chk_tap_onehot: assert property (armed |-> $onehot(tap_sel[g]))
            else $error("tap select not one-hot");
        chk_tap_tracks: assert property (
            armed && $past(ce) |-> tap_sel[g] == (256'h1 << $past(wiper_pos[g])))
            else $error("tap select does not follow wiper");
    end
endmodule : quad_wiper_checker

bind quad_wiper_register_control quad_wiper_checker chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .write_guard_n(write_guard_n), .scl_i(scl_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .wiper_pos(wiper_pos), .tap_sel(tap_sel),
    .bus_active(bus_active), .nv_refused(nv_refused)
);

`default_nettype wire

// *** bus_ctrl_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// two-wire controller; its clock stands high between frames
module bus_ctrl_model (
    // wire side
    output logic scl,
    output logic sda_pull,
    input wire logic sda_in
);
    // one 125 ns bit slot; data moves 32 ns after the fall so it never races a start
    task automatic bit_slot(input logic b, output logic r);
        sda_pull = !b;
        #31 scl = 1'b1;
        #31 r = sda_in;
        #31 scl = 1'b0;
        #32;
    endtask : bit_slot

    // start held long enough for the device to see it with clock still high
    task automatic start();
        sda_pull = 1'b0;
        #31 scl = 1'b1;
        #31 sda_pull = 1'b1;
        #62 scl = 1'b0;
        #32;
    endtask : start

    task automatic stop();
        sda_pull = 1'b1;
        #31 scl = 1'b1;
        #31 sda_pull = 1'b0;
        #63;
    endtask : stop

    // byte out, msb first, then the device's acknowledge slot
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
        bit_slot(1'b1, r);
        ack = !r;
    endtask : send

    // byte in; more low answers not-acknowledge
    task automatic recv(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, r);
            d[i] = r;
        end
        bit_slot(!more, r);
    endtask : recv

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
endmodule : bus_ctrl_model

`default_nettype wire

// *** quad_wiper_register_control_test.sv ***
`timescale 1ns/1ns
`default_nettype none

`define CHECK(got, exp, msg) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("wrong value at %0t ns: %s", $time, msg); \
    end \
end

module quad_wiper_register_control_test;
    import wiper_ctrl_pkg::*;

    localparam logic [7:0] WV [4] = '{8'h00, 8'hFF, 8'h80, 8'h01};
    localparam logic [7:0] STEP_FROM [4] = '{8'hFF, 8'hFF, 8'h00, 8'h00};
    localparam logic [7:0] STEP_TO [4] = '{8'hFF, 8'hFE, 8'h00, 8'h01};
    localparam logic [3:0] STEP_UP = 4'h9;

    // bench drives and design outputs
    logic sys_clk;
    logic rst_b;
    logic ce;
    logic [3:0] straps;
    logic [3:0] dev_sel;
    logic write_guard_n;
    wire logic scl;
    wire logic sda_pull;
    wire logic sda_wire;
    wire logic sda_o;
    wire logic sda_oe;
    wire logic bus_active;
    wire logic nv_refused;
    wire logic [NUM_CH-1:0][WIPER_W-1:0] wiper_pos;
    wire logic [NUM_CH-1:0][NUM_TAPS-1:0] tap_sel;
    int err_count;
    int cmp_count;

    always #5 sys_clk = ~sys_clk;

    // open-drain wire with pull-up: low if anyone pulls
    assign sda_wire = !(sda_pull || (sda_oe && !sda_o));

    bus_ctrl_model ctl (.scl(scl), .sda_pull(sda_pull), .sda_in(sda_wire));

    quad_wiper_register_control dut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .scl_i(scl),
        .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe), .bus_select_bit0(straps[0]),
        .bus_select_bit1(straps[1]), .bus_select_bit2(straps[2]), .bus_select_bit3(straps[3]),
        .write_guard_n(write_guard_n), .wiper_pos(wiper_pos), .tap_sel(tap_sel),
        .bus_active(bus_active), .nv_refused(nv_refused));

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    function automatic instr_t ins(input logic [3:0] op, input int c, input int s);
        return '{op: op, slot: s[1:0], chan: c[1:0]};
    endfunction : ins

    function automatic logic [7:0] pat(input int c, input int s);
        return {c[1:0], s[1:0], ~c[1:0], ~s[1:0]};
    endfunction : pat

    // write frame: address, instruction, optional data byte
    task automatic put(input instr_t i, input logic [7:0] d, input logic dat, input logic exp);
        logic a;
        ctl.start();
        ctl.send({ADDR_PREFIX, dev_sel, 1'b0}, a);
        `CHECK(a, exp, "address acknowledge")
        if (a) begin
            ctl.send(i, a);
            if (dat) ctl.send(d, a);
        end
        ctl.stop();
        `CHECK(bus_active, 1'b0, "engine busy after stop")
    endtask : put

    // read frame after setting the instruction
    task automatic get(input instr_t i, output logic [7:0] q);
        logic a;
        put(i, 8'h00, 1'b0, 1'b1);
        ctl.start();
        ctl.send({ADDR_PREFIX, dev_sel, 1'b1}, a);
        `CHECK(a, 1'b1, "read address acknowledge")
        ctl.recv(1'b0, q);
        ctl.stop();
    endtask : get

    task automatic chk_pos(input int c, input logic [7:0] v);
        `CHECK(wiper_pos[c], v, "wiper position")
        `CHECK(tap_sel[c], 256'h1 << v, "tap select")
    endtask : chk_pos

    // all sixteen slots written before any is read, so aliasing shows
    task automatic t_saved();
        logic [7:0] q;
        for (int k = 0; k < NUM_SAVED; k++) begin
            put(ins(OP_WRITE_SAVED, k / 4, k % 4), pat(k / 4, k % 4), 1'b1, 1'b1);
        end
        for (int k = 0; k < NUM_SAVED; k++) begin
            get(ins(OP_READ_SAVED, k / 4, k % 4), q);
            `CHECK(q, pat(k / 4, k % 4), "saved slot readback")
        end
    endtask : t_saved

    task automatic t_reset();
        rst_b = 1'b0;
        tick(3);
        rst_b = 1'b1;
        tick(8);
        for (int c = 0; c < NUM_CH; c++) chk_pos(c, pat(c, 0));
    endtask : t_reset

    task automatic t_wiper();
        logic [7:0] q;
        for (int c = 0; c < NUM_CH; c++) begin
            put(ins(OP_WRITE_WIPER, c, 0), WV[c], 1'b1, 1'b1);
        end
        for (int c = 0; c < NUM_CH; c++) begin
            chk_pos(c, WV[c]);
            get(ins(OP_READ_WIPER, c, 0), q);
            `CHECK(q, WV[c], "wiper readback")
        end
    endtask : t_wiper

    // one strap bit off must be ignored
    task automatic t_select();
        straps = 4'hA;
        dev_sel = 4'hB;
        tick(5);
        put(ins(OP_WRITE_WIPER, 0, 0), 8'h77, 1'b1, 1'b0);
        chk_pos(0, WV[0]);
        dev_sel = 4'hA;
        put(ins(OP_WRITE_WIPER, 0, 0), 8'h77, 1'b1, 1'b1);
        chk_pos(0, 8'h77);
    endtask : t_select

    task automatic t_guard();
        logic [7:0] q;
        write_guard_n = 1'b0;
        tick(5);
        put(ins(OP_WRITE_SAVED, 1, 2), 8'h5A, 1'b1, 1'b1);
        `CHECK(nv_refused, 1'b1, "saved write not refused")
        put(ins(OP_WRITE_WIPER, 1, 0), 8'h5A, 1'b1, 1'b1);
        chk_pos(1, 8'h5A);
        put(ins(OP_STORE, 1, 2), 8'h00, 1'b0, 1'b1);
        `CHECK(nv_refused, 1'b1, "store not refused")
        get(ins(OP_READ_SAVED, 1, 2), q);
        `CHECK(q, pat(1, 2), "saved slot changed while guarded")
        write_guard_n = 1'b1;
        tick(5);
        put(ins(OP_STORE, 1, 2), 8'h00, 1'b0, 1'b1);
        get(ins(OP_READ_SAVED, 1, 2), q);
        `CHECK(q, 8'h5A, "store into saved slot")
        `CHECK(nv_refused, 1'b0, "refusal flag not cleared")
    endtask : t_guard

    task automatic t_copy();
        put(ins(OP_WRITE_WIPER, 2, 0), 8'h11, 1'b1, 1'b1);
        put(ins(OP_RECALL, 2, 3), 8'h00, 1'b0, 1'b1);
        chk_pos(2, pat(2, 3));
    endtask : t_copy

    // steps at both ends must saturate
    task automatic t_step();
        for (int i = 0; i < 4; i++) begin
            put(ins(OP_WRITE_WIPER, 3, 0), STEP_FROM[i], 1'b1, 1'b1);
            put(ins(OP_STEP, 3, 0), {7'h00, STEP_UP[i]}, 1'b1, 1'b1);
            chk_pos(3, STEP_TO[i]);
        end
    endtask : t_step

    // enable low freezes the block, so a whole frame goes unseen
    task automatic t_hold();
        tick(1);
        ce = 1'b0;
        put(ins(OP_WRITE_WIPER, 0, 0), 8'h33, 1'b1, 1'b0);
        tick(1);
        ce = 1'b1;
        tick(5);
        chk_pos(0, 8'h77);
    endtask : t_hold

    task automatic report_and_stop();
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        ce = 1'b1;
        straps = 4'h0;
        dev_sel = 4'h0;
        write_guard_n = 1'b1;
        err_count = 0;
        cmp_count = 0;
        tick(5);
        rst_b = 1'b1;
        tick(8);
        t_saved();
        t_reset();
        t_wiper();
        t_select();
        t_guard();
        t_copy();
        t_step();
        t_hold();
        report_and_stop();
    end
endmodule : quad_wiper_register_control_test

`default_nettype wire
